// *** common/abr_pkg.sv ***
// Shared constants and carrier types of the aligned bus read cycle unit.
// Assumes a single 100 MHz clock and active-low bus pins sampled on its rising edge.
//
// Functional notes
// - Odd words and longs not divisible by four are misaligned; bytes never are.
// - No alignment restriction; misaligned operands become a series of aligned cycles.
// - An instruction fetch at an odd address raises an address error.
// - The size code describes only the current bus cycle, not remaining bytes.
// - An odd long read runs byte at 001, word at 010, byte at 100.
// - A long at an odd-word address takes exactly two word cycles.
// - A word at an odd address takes two byte cycles.
// - Byte, word and long reads serve uncached cases and burst-inhibited line remainders.
// - Every cycle except a line remainder is aligned: words on even addresses, longs on long boundaries.
// - Low address bits: byte points at it, word has bit zero low, long both low outside line remainders.
// - Burst-inhibited line cycles repeat the original two low address bits.
// - The inbound cache-inhibit response is ignored when latching read data.
// - The opening clock drives address, page attributes, type, modifier and read direction.
// - Cache-inhibit output asserts for non-cachable pages or alternate address spaces.
// - The start strobe asserts in the opening clock, with cycle-active unless already on.
// - The start strobe negates in the second clock, lasting one bus clock.
// - Acknowledge is sampled from the second clock on; without it wait clocks follow.
// - Cycle-active stays on if another cycle is ready, otherwise it negates; the unit negates it between operands even with a request waiting.
// - Size code: byte 01, word 10, long 00, line 11, upper bit first.
package abr_pkg;

  // ----------------------------------------
  // Size codes and byte counts
  // ----------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_LINE = 2'h3;

  localparam logic [2:0] BYTES_BYTE = 3'h1;
  localparam logic [2:0] BYTES_WORD = 3'h2;
  localparam logic [2:0] BYTES_LONG = 3'h4;

  localparam logic [1:0] LINE_REST_CNT = 2'h3;
  localparam logic [1:0] LINE_STEP     = 2'h1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [1:0]  SIZE_RST = 2'h0;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_BYTE,
    OP_WORD,
    OP_LONG,
    OP_LINE_REST
  } abr_op_type;

  typedef struct packed {
    logic [31:0] addr;
    abr_op_type  kind;
    logic        fetch;
    logic        noncache;
    logic        alt_space;
    logic [1:0]  upa;
    logic [1:0]  ttype;
    logic [2:0]  tmod;
  } abr_req_type;

  typedef struct packed {
    logic [31:0] data;
    logic        addr_err;
  } abr_result_type;

endpackage : abr_pkg

// *** hdl/abr_piece_plan.sv ***
// Chooses the aligned size of the next bus cycle of an operand.
// Assumes the remaining byte count is one to four and the offset is the cycle address.
`timescale 1ns/1ps

module abr_piece_plan
  import abr_pkg::*;
(
  // Piece position
  input  wire logic [1:0] off_in,
  input  wire logic [2:0] rem_in,
  input  wire logic       line_in,
  // Chosen cycle
  output logic      [1:0] size_out
);

  // ----------------------------------------
  // Largest aligned piece that fits
  // ----------------------------------------
  always_comb begin
    if (line_in) begin
      size_out = SIZE_LONG;
    end else if (off_in[0] || rem_in == BYTES_BYTE) begin
      size_out = SIZE_BYTE;
    end else if (off_in[1] || rem_in < BYTES_LONG) begin
      size_out = SIZE_WORD;
    end else begin
      size_out = SIZE_LONG;
    end
  end

endmodule : abr_piece_plan

// *** hdl/abr_pair_buf.sv ***
// Small FIFO holding finished read results until the requester takes them.
// Assumes the writer checks in_ready_out before pushing.
`timescale 1ns/1ps

module abr_pair_buf #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 2,
  parameter int LW    = $clog2(DEPTH + 1),
  parameter int PW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Draining side
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in,
  output logic      [LW-1:0]    level_out
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [LW-1:0]    level_r, level_nxt;
  logic             push, pop;

  always_comb begin
    push       = in_valid_in && (level_r < LW'(DEPTH));
    pop        = (level_r != '0) && out_ready_in;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
    end
    level_nxt = level_r + LW'(push) - LW'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      level_r  <= level_nxt;
    end
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  assign in_ready_out  = level_r < LW'(DEPTH);
  assign out_valid_out = level_r != '0;
  assign out_data_out  = mem_r[rd_ptr_r];
  assign level_out     = level_r;

endmodule : abr_pair_buf

// *** hdl/abr_read_unit.sv ***
// Read cycle controller: splits operands into aligned bus cycles and runs the handshake.
// Assumes a slave that drives data with an active-low acknowledge sampled on clk_in.
`timescale 1ns/1ps

module abr_read_unit
  import abr_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic           clk_in,
  input  wire logic           rst_in,
  // Operand requests
  input  wire logic           req_valid_in,
  input  wire abr_req_type    req_in,
  output logic                req_ready_out,
  // Operand results
  output logic                res_valid_out,
  output abr_result_type      res_out,
  input  wire logic           res_ready_in,
  output logic                addr_error_out,
  // Bus address and attributes
  output logic      [31:0]    addr_out,
  output logic                size_code_bit1_out,
  output logic                size_code_bit0_out,
  output logic                rw_out,
  output logic      [1:0]     user_page_attributes_out,
  output logic      [1:0]     transfer_type_code_out,
  output logic      [2:0]     transfer_modifier_code_out,
  output logic                cache_inhibit_output_n_out,
  // Bus handshake
  output logic                transfer_start_strobe_n_out,
  output logic                cycle_active_n_out,
  input  wire logic [31:0]    data_in,
  input  wire logic           transfer_acknowledge_n_in
);

  localparam int LVW = $clog2(BUF_DEPTH + 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT,
    ST_LGAP
  } abr_state_type;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] bytes_of(input logic [1:0] sz);
    logic [2:0] n;
    n = BYTES_LONG;
    if (sz == SIZE_BYTE) begin
      n = BYTES_BYTE;
    end else if (sz == SIZE_WORD) begin
      n = BYTES_WORD;
    end
    return n;
  endfunction : bytes_of

  function automatic logic [31:0] pick_lanes(input logic [1:0] sz, input logic [1:0] off, input logic [31:0] d);
    logic [31:0] r;
    r = d;
    if (sz == SIZE_BYTE) begin
      case (off)
        2'h0: r = {24'h000000, d[31:24]};
        2'h1: r = {24'h000000, d[23:16]};
        2'h2: r = {24'h000000, d[15:8]};
        default: r = {24'h000000, d[7:0]};
      endcase
    end else if (sz == SIZE_WORD) begin
      r = off[1] ? {16'h0000, d[15:0]} : {16'h0000, d[31:16]};
    end
    return r;
  endfunction : pick_lanes

  // ----------------------------------------
  // State
  // ----------------------------------------
  abr_state_type  state_r, state_nxt;
  abr_req_type    op_r, op_nxt;
  logic [31:0]    cur_addr_r, cur_addr_nxt;
  logic [2:0]     rem_r, rem_nxt;
  logic [1:0]     lines_left_r, lines_left_nxt;
  logic [31:0]    acc_r, acc_nxt;
  logic           addr_err_r, addr_err_nxt;
  logic           req_ready_r, req_ready_nxt;
  logic [31:0]    addr_r, addr_nxt;
  logic [1:0]     size_r, size_nxt;
  logic [1:0]     upa_r, upa_nxt;
  logic [1:0]     tt_r, tt_nxt;
  logic [2:0]     tm_r, tm_nxt;
  logic           cache_inhibit_output_n_r, cache_inhibit_output_n_nxt;
  logic           ts_n_r, ts_n_nxt;
  logic           tip_n_r, tip_n_nxt;
  logic           rw_r;

  logic           accept, ta, last_piece, push, buf_ready, pop;
  abr_result_type push_data;
  logic [63:0]    wide;
  logic [1:0]     plan_size;
  logic [LVW-1:0] level, level_nxt;

  abr_piece_plan u_plan (
    .off_in   (cur_addr_nxt[1:0]),
    .rem_in   (rem_nxt),
    .line_in  (op_nxt.kind == OP_LINE_REST),
    .size_out (plan_size)
  );

  abr_pair_buf #(
    .WIDTH ($bits(abr_result_type)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (push),
    .in_data_in    (push_data),
    .in_ready_out  (buf_ready),
    .out_valid_out (res_valid_out),
    .out_data_out  (res_out),
    .out_ready_in  (res_ready_in),
    .level_out     (level)
  );

  // ----------------------------------------
  // Operand sequencing
  // ----------------------------------------
  // A new operand is only taken when the buffer has a slot, so the final push never meets a full buffer.
  always_comb begin
    ta             = !transfer_acknowledge_n_in;
    accept         = (state_r == ST_IDLE) && req_valid_in && req_ready_r;
    last_piece     = rem_r == bytes_of(size_r);
    state_nxt      = state_r;
    op_nxt         = op_r;
    cur_addr_nxt   = cur_addr_r;
    rem_nxt        = rem_r;
    lines_left_nxt = lines_left_r;
    acc_nxt        = acc_r;
    addr_err_nxt   = 1'b0;
    push           = 1'b0;
    push_data      = '{data: acc_r, addr_err: 1'b0};
    wide           = {32'h00000000, acc_r} << {bytes_of(size_r), 3'h0};
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          op_nxt  = req_in;
          acc_nxt = '0;
          if (req_in.fetch && req_in.addr[0]) begin
            addr_err_nxt = 1'b1;
            push         = 1'b1;
            push_data    = '{data: '0, addr_err: 1'b1};
          end else if (req_in.kind == OP_LINE_REST) begin
            cur_addr_nxt   = {req_in.addr[31:4], req_in.addr[3:2] + LINE_STEP, req_in.addr[1:0]};
            rem_nxt        = BYTES_LONG;
            lines_left_nxt = LINE_REST_CNT;
            state_nxt      = ST_START;
          end else begin
            cur_addr_nxt = req_in.addr;
            rem_nxt      = (req_in.kind == OP_BYTE) ? BYTES_BYTE :
                           (req_in.kind == OP_WORD) ? BYTES_WORD : BYTES_LONG;
            state_nxt    = ST_START;
          end
        end
      end
      ST_START: begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        // Data is taken only on acknowledge; the inbound cache-inhibit level plays no part.
        if (ta) begin
          if (op_r.kind == OP_LINE_REST) begin
            push           = 1'b1;
            push_data      = '{data: data_in, addr_err: 1'b0};
            lines_left_nxt = lines_left_r - 2'h1;
            cur_addr_nxt   = {cur_addr_r[31:4], cur_addr_r[3:2] + LINE_STEP, cur_addr_r[1:0]};
            // Without a free slot after this push the next long waits in the gap, with cycle-active released.
            if (lines_left_r == 2'h1) begin
              state_nxt = ST_IDLE;
            end else if (level < LVW'(BUF_DEPTH - 1) || (res_valid_out && res_ready_in)) begin
              state_nxt = ST_START;
            end else begin
              state_nxt = ST_LGAP;
            end
          end else begin
            acc_nxt      = wide[31:0] | pick_lanes(size_r, addr_r[1:0], data_in);
            rem_nxt      = rem_r - bytes_of(size_r);
            cur_addr_nxt = cur_addr_r + {29'h00000000, bytes_of(size_r)};
            if (last_piece) begin
              push      = 1'b1;
              push_data = '{data: acc_nxt, addr_err: 1'b0};
              state_nxt = ST_IDLE;
            end else begin
              state_nxt = ST_START;
            end
          end
        end
      end
      default: begin
        if (buf_ready) begin
          state_nxt = ST_START;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Bus drive
  // ----------------------------------------
  always_comb begin
    pop           = res_valid_out && res_ready_in;
    level_nxt     = level + LVW'(push) - LVW'(pop);
    req_ready_nxt = (state_nxt == ST_IDLE) && (level_nxt < LVW'(BUF_DEPTH));
    addr_nxt      = addr_r;
    size_nxt      = size_r;
    upa_nxt       = upa_r;
    tt_nxt        = tt_r;
    tm_nxt        = tm_r;
    cache_inhibit_output_n_nxt   = cache_inhibit_output_n_r;
    ts_n_nxt      = 1'b1;
    tip_n_nxt     = (state_nxt == ST_IDLE) || (state_nxt == ST_LGAP);
    if (state_nxt == ST_START) begin
      // Low bits carry the piece offset; line remainders keep the original ones.
      addr_nxt    = cur_addr_nxt;
      size_nxt    = plan_size;
      upa_nxt     = op_nxt.upa;
      tt_nxt      = op_nxt.ttype;
      tm_nxt      = op_nxt.tmod;
      cache_inhibit_output_n_nxt = !(op_nxt.noncache || op_nxt.alt_space);
      ts_n_nxt    = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r      <= ST_IDLE;
      op_r         <= '0;
      cur_addr_r   <= ADDR_RST;
      rem_r        <= '0;
      lines_left_r <= '0;
      acc_r        <= '0;
      addr_err_r   <= 1'b0;
      req_ready_r  <= 1'b0;
      addr_r       <= ADDR_RST;
      size_r       <= SIZE_RST;
      upa_r        <= '0;
      tt_r         <= '0;
      tm_r         <= '0;
      cache_inhibit_output_n_r    <= 1'b1;
      ts_n_r       <= 1'b1;
      tip_n_r      <= 1'b1;
      rw_r         <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      op_r         <= op_nxt;
      cur_addr_r   <= cur_addr_nxt;
      rem_r        <= rem_nxt;
      lines_left_r <= lines_left_nxt;
      acc_r        <= acc_nxt;
      addr_err_r   <= addr_err_nxt;
      req_ready_r  <= req_ready_nxt;
      addr_r       <= addr_nxt;
      size_r       <= size_nxt;
      upa_r        <= upa_nxt;
      tt_r         <= tt_nxt;
      tm_r         <= tm_nxt;
      cache_inhibit_output_n_r    <= cache_inhibit_output_n_nxt;
      ts_n_r       <= ts_n_nxt;
      tip_n_r      <= tip_n_nxt;
      rw_r         <= 1'b1;
    end
  end

  assign req_ready_out               = req_ready_r;
  assign addr_error_out              = addr_err_r;
  assign addr_out                    = addr_r;
  assign size_code_bit1_out          = size_r[1];
  assign size_code_bit0_out          = size_r[0];
  assign rw_out                      = rw_r;
  assign user_page_attributes_out    = upa_r;
  assign transfer_type_code_out      = tt_r;
  assign transfer_modifier_code_out  = tm_r;
  assign cache_inhibit_output_n_out  = cache_inhibit_output_n_r;
  assign transfer_start_strobe_n_out = ts_n_r;
  assign cycle_active_n_out          = tip_n_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_ts_one_clock: assert property (!ts_n_r |=> ts_n_r)
    else $error("Start strobe held longer than one clock.");
  chk_tip_with_ts: assert property (!ts_n_r |-> !tip_n_r)
    else $error("Cycle-active not asserted with start strobe.");
  chk_word_even: assert property ((!ts_n_r && size_r == SIZE_WORD) |-> !addr_r[0])
    else $error("Word cycle on odd address.");
  chk_long_low_zero: assert property ((!ts_n_r && size_r == SIZE_LONG && op_r.kind != OP_LINE_REST)
      |-> addr_r[1:0] == 2'h0)
    else $error("Long cycle not long aligned.");
  chk_line_low_bits: assert property ((!ts_n_r && op_r.kind == OP_LINE_REST)
      |-> addr_r[1:0] == op_r.addr[1:0] && size_r == SIZE_LONG)
    else $error("Line remainder lost original low address bits.");
  chk_read_dir_attr: assert property (!ts_n_r |-> rw_r && upa_r == op_r.upa && tt_r == op_r.ttype)
    else $error("Read direction or attributes wrong at cycle start.");
  chk_cache_inhibit_output_level: assert property (!ts_n_r |-> cache_inhibit_output_n_r == !(op_r.noncache || op_r.alt_space))
    else $error("Cache-inhibit output wrong.");
  chk_wait_no_ta: assert property ((state_r == ST_WAIT && transfer_acknowledge_n_in)
      |=> state_r == ST_WAIT && $stable(addr_r) && ts_n_r)
    else $error("Cycle ended without acknowledge.");
  chk_odd_long_split: assert property ((!ts_n_r && op_r.kind == OP_LONG && op_r.addr[1:0] == 2'h1)
      |-> (addr_r[1:0] == 2'h1 && size_r == SIZE_BYTE) || (addr_r[1:0] == 2'h2 && size_r == SIZE_WORD)
       || (addr_r[1:0] == 2'h0 && size_r == SIZE_BYTE))
    else $error("Odd long split wrong.");
  chk_fetch_odd_err: assert property ((accept && req_in.fetch && req_in.addr[0])
      |=> addr_error_out && state_r == ST_IDLE ##1 !addr_error_out)
    else $error("Odd fetch did not raise a single address error.");
  chk_tip_release: assert property ((state_r == ST_WAIT && ta && last_piece && op_r.kind != OP_LINE_REST)
      |=> tip_n_r)
    else $error("Cycle-active not released after last cycle.");
  chk_odd_word_bytes: assert property ((!ts_n_r && op_r.kind == OP_WORD && op_r.addr[0])
      |-> size_r == SIZE_BYTE)
    else $error("Odd word not split into byte cycles.");
  chk_size_fits: assert property ((!ts_n_r && op_r.kind != OP_LINE_REST) |-> bytes_of(size_r) <= rem_r)
    else $error("Cycle size exceeds remaining operand bytes.");
  chk_line_tip_kept: assert property ((state_r == ST_WAIT && ta && op_r.kind == OP_LINE_REST
      && lines_left_r != 2'h1 && level == '0) |=> !ts_n_r && !tip_n_r)
    else $error("Line remainder dropped cycle-active with a free slot.");
  chk_ascending: assert property ((!ts_n_r && $past(state_r) == ST_WAIT && op_r.kind != OP_LINE_REST)
      |-> addr_r == $past(addr_r) + {29'h00000000, bytes_of($past(size_r))})
    else $error("Next piece not at the following address.");

  cov_odd_long: cover property (!ts_n_r && op_r.kind == OP_LONG && addr_r[2:0] == 3'h4 && size_r == SIZE_BYTE);
  cov_wait_clock: cover property (state_r == ST_WAIT && transfer_acknowledge_n_in ##1 ta);
  cov_line_rest: cover property (op_r.kind == OP_LINE_REST && push && lines_left_r == 2'h1);
  cov_stall_full: cover property (res_valid_out && !res_ready_in && !buf_ready);
  cov_line_direct: cover property (state_r == ST_WAIT && ta && op_r.kind == OP_LINE_REST ##1 !ts_n_r);

endmodule : abr_read_unit

// *** bench/abr_slave_model.sv ***
// Behavioural memory slave that answers the read unit's aligned bus cycles.
// Assumes it sees the unit's bus outputs and answers on the rising edge of clk_in.
`timescale 1ns/1ps

module abr_slave_model
  import abr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Bus from the read unit, and the bench's wait count
  input  wire logic [31:0] addr_in,
  input  wire logic [1:0]  size_in,
  input  wire logic        strobe_n_in,
  input  wire logic [3:0]  wait_in,
  // Answer
  output logic      [31:0] data_out,
  output logic             ack_n_out
);
  logic [31:0] a_r;
  logic [1:0]  s_r;
  logic [3:0]  cnt_r;
  logic        busy_r;

  // Unselected lanes carry the inverse byte, so a unit reading the wrong lane cannot pass.
  function automatic logic [31:0] lanes(input logic [31:0] a, input logic [1:0] s);
    logic [31:0] x;
    logic        on;
    for (int i = 0; i < 4; i++) begin
      x  = {a[31:2], 2'(i)};
      on = (s == SIZE_LONG) || (s == SIZE_LINE) || (s == SIZE_WORD && a[1] == i[1]) || (s == SIZE_BYTE && a[1:0] == 2'(i));
      lanes[31-8*i -: 8] = on ? (x[7:0] ^ x[15:8] ^ 8'hA5) : ~(x[7:0] ^ x[15:8] ^ 8'hA5);
    end
  endfunction : lanes

  always @(posedge clk_in) begin
    if (rst_in) begin
      ack_n_out <= 1'b1;
      busy_r    <= 1'b0;
      cnt_r     <= 4'h0;
      a_r       <= 32'h0;
      s_r       <= 2'h0;
      data_out  <= 32'h0;
    end else if (!ack_n_out) begin
      ack_n_out <= 1'b1;
      data_out  <= ~data_out;
    end else if (!strobe_n_in) begin
      a_r <= addr_in;
      s_r <= size_in;
      if (wait_in == 4'h0) begin
        ack_n_out <= 1'b0;
        data_out  <= lanes(addr_in, size_in);
      end else begin
        busy_r   <= 1'b1;
        cnt_r    <= wait_in - 4'h1;
        data_out <= ~data_out;
      end
    end else if (busy_r) begin
      if (cnt_r == 4'h0) begin
        busy_r    <= 1'b0;
        ack_n_out <= 1'b0;
        data_out  <= lanes(a_r, s_r);
      end else begin
        cnt_r    <= cnt_r - 4'h1;
        data_out <= ~data_out;
      end
    end
  end
endmodule : abr_slave_model

// *** bench/tb.sv ***
// Self-checking testbench of the aligned bus read cycle unit.
// Assumes the unit's hand-over timing and the behavioural slave model beside it.
`timescale 1ns/1ps

module tb
  import abr_pkg::*;
;
  logic           clk_in = 1'b0;
  logic           rst_in = 1'b1;
  logic           req_valid = 1'b0;
  abr_req_type    req = '0;
  logic           res_ready = 1'b1;
  logic [3:0]     slow = 4'h0;
  logic           req_ready, res_valid, err_p, rw, ci_n, ts_n, tip_n, sz1, sz0, ack_n;
  abr_result_type res;
  logic [31:0]    bus_a, bus_d;
  logic [1:0]     upa, tt;
  logic [2:0]     tm;
  logic           prev_tip_n = 1'b1;
  logic           prev_ts_n = 1'b1;
  logic [31:0]    seen_a[$];
  logic [1:0]     seen_s[$];
  int             n_pulse = 0;
  int             n_mismatch = 0;
  int             checked = 0;

  always #5 clk_in = ~clk_in;

  abr_read_unit u_dut (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid), .req_in(req),
    .req_ready_out(req_ready), .res_valid_out(res_valid), .res_out(res), .res_ready_in(res_ready),
    .addr_error_out(err_p), .addr_out(bus_a), .size_code_bit1_out(sz1), .size_code_bit0_out(sz0),
    .rw_out(rw), .user_page_attributes_out(upa), .transfer_type_code_out(tt),
    .transfer_modifier_code_out(tm), .cache_inhibit_output_n_out(ci_n),
    .transfer_start_strobe_n_out(ts_n), .cycle_active_n_out(tip_n), .data_in(bus_d),
    .transfer_acknowledge_n_in(ack_n));

  abr_slave_model u_slave (.clk_in(clk_in), .rst_in(rst_in), .addr_in(bus_a), .size_in({sz1, sz0}),
    .strobe_n_in(ts_n), .wait_in(slow), .data_out(bus_d), .ack_n_out(ack_n));

  function automatic logic [7:0] mb(input logic [31:0] x);
    return x[7:0] ^ x[15:8] ^ 8'hA5;
  endfunction : mb

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: saw %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Every bus cycle is recorded at the edge that ends its opening clock.
  always @(posedge clk_in) begin
    if (!rst_in && ts_n === 1'b0) begin
      seen_a.push_back(bus_a);
      seen_s.push_back({sz1, sz0});
      check({rw, upa, tt, tm}, {1'b1, req.upa, req.ttype, req.tmod}, "attributes");
      check(ci_n, !(req.noncache | req.alt_space), "cache inhibit");
      check(tip_n, 1'b0, "cycle active");
      check(prev_ts_n, 1'b1, "strobe width");
      if (seen_a.size() > 1 && req.kind != OP_LINE_REST) check(prev_tip_n, 1'b0, "cycle active kept");
    end
    if (!rst_in && err_p === 1'b1) n_pulse++;
    prev_tip_n <= tip_n;
    prev_ts_n  <= ts_n;
  end

  task automatic run_op(input abr_op_type k, input logic [31:0] a, input logic f, input logic nc, input logic al);
    int t;
    seen_a.delete();
    seen_s.delete();
    @(posedge clk_in);
    req_valid <= 1'b1;
    req <= '{addr: a, kind: k, fetch: f, noncache: nc, alt_space: al, upa: a[5:4], ttype: a[1:0], tmod: a[6:4]};
    t = 0;
    do begin
      @(posedge clk_in);
      t++;
    end while (req_ready !== 1'b1 && t < 100);
    req_valid <= 1'b0;
    if (t >= 100) begin
      n_mismatch++;
      summarize();
    end
  endtask : run_op

  task automatic take(input logic [32:0] exp);
    int t;
    t = 0;
    do begin
      @(posedge clk_in);
      t++;
    end while (!(res_valid === 1'b1 && res_ready === 1'b1) && t < 200);
    if (t >= 200) begin
      n_mismatch++;
      summarize();
    end else begin
      check(res, exp, "result data");
    end
  endtask : take

  task automatic piece(input int i, input logic [31:0] a, input logic [1:0] s);
    check(seen_a.size() > i, 1'b1, "cycle missing");
    if (seen_a.size() > i) check({seen_a[i], seen_s[i]}, {a, s}, "cycle address and size");
  endtask : piece

  task automatic s_aligned();
    run_op(OP_BYTE, 32'h103, 1'b0, 1'b1, 1'b0);
    take({24'h0, mb(32'h103), 1'b0});
    piece(0, 32'h103, SIZE_BYTE);
    check(tip_n, 1'b1, "cycle active idle");
    run_op(OP_WORD, 32'h202, 1'b0, 1'b0, 1'b1);
    take({16'h0, mb(32'h202), mb(32'h203), 1'b0});
    piece(0, 32'h202, SIZE_WORD);
    run_op(OP_LONG, 32'h304, 1'b0, 1'b0, 1'b0);
    take({mb(32'h304), mb(32'h305), mb(32'h306), mb(32'h307), 1'b0});
    piece(0, 32'h304, SIZE_LONG);
    check(seen_a.size(), 1, "cycle count");
  endtask : s_aligned

  task automatic s_odd_long();
    slow <= 4'h2;
    run_op(OP_LONG, 32'h401, 1'b0, 1'b0, 1'b0);
    take({mb(32'h401), mb(32'h402), mb(32'h403), mb(32'h404), 1'b0});
    piece(0, 32'h401, SIZE_BYTE);
    piece(1, 32'h402, SIZE_WORD);
    piece(2, 32'h404, SIZE_BYTE);
    check(seen_a.size(), 3, "cycle count");
    slow <= 4'h0;
  endtask : s_odd_long

  task automatic s_split();
    run_op(OP_LONG, 32'h502, 1'b0, 1'b0, 1'b0);
    take({mb(32'h502), mb(32'h503), mb(32'h504), mb(32'h505), 1'b0});
    piece(1, 32'h504, SIZE_WORD);
    check({seen_a[0], seen_s[0]}, {32'h502, SIZE_WORD}, "first word");
    check(seen_a.size(), 2, "cycle count");
    run_op(OP_WORD, 32'h603, 1'b0, 1'b0, 1'b0);
    take({16'h0, mb(32'h603), mb(32'h604), 1'b0});
    piece(0, 32'h603, SIZE_BYTE);
    piece(1, 32'h604, SIZE_BYTE);
  endtask : s_split

  task automatic s_fetch();
    run_op(OP_WORD, 32'h701, 1'b1, 1'b0, 1'b0);
    take({32'h0, 1'b1});
    // The pulse counter is bumped at the edge that take returns on, so let that edge settle first.
    @(posedge clk_in);
    check({n_pulse, seen_a.size()}, {32'd1, 32'd0}, "fetch error");
    run_op(OP_WORD, 32'h700, 1'b1, 1'b0, 1'b0);
    take({16'h0, mb(32'h700), mb(32'h701), 1'b0});
  endtask : s_fetch

  task automatic s_line();
    res_ready <= 1'b0;
    run_op(OP_LINE_REST, 32'h80D, 1'b0, 1'b0, 1'b0);
    repeat (40) @(posedge clk_in);
    check(seen_a.size(), 2, "stalled while full");
    res_ready <= 1'b1;
    take({mb(32'h800), mb(32'h801), mb(32'h802), mb(32'h803), 1'b0});
    take({mb(32'h804), mb(32'h805), mb(32'h806), mb(32'h807), 1'b0});
    take({mb(32'h808), mb(32'h809), mb(32'h80A), mb(32'h80B), 1'b0});
    piece(0, 32'h801, SIZE_LONG);
    piece(1, 32'h805, SIZE_LONG);
    piece(2, 32'h809, SIZE_LONG);
    check(seen_a.size(), 3, "line cycle count");
  endtask : s_line

  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    s_aligned();
    s_odd_long();
    s_split();
    s_fetch();
    s_line();
    summarize();
  end
endmodule : tb
